// *** shared/spms_pkg.sv ***
// Register map, field positions, reset values and rate table of the
// serial master/slave port.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word a register.
package spms_pkg;

  // Byte addresses of the registers
  localparam logic [3:0] SPMS_CTRL_OFS = 4'h0;
  localparam logic [3:0] SPMS_STAT_OFS = 4'h4;
  localparam logic [3:0] SPMS_DATA_OFS = 4'h8;
  localparam logic [3:0] SPMS_DIR_OFS  = 4'hc;

  // serial_control_reg fields
  localparam int SPMS_CTL_IE   = 7;
  localparam int SPMS_CTL_EN   = 6;
  localparam int SPMS_CTL_ORD  = 5;
  localparam int SPMS_CTL_MST  = 4;
  localparam int SPMS_CTL_CPOL = 3;
  localparam int SPMS_CTL_CPHA = 2;

  // serial_status_reg fields
  localparam int SPMS_STAT_FLAG = 7;
  localparam int SPMS_STAT_WRITE_COLLISION_FLAG = 6;
  localparam int SPMS_STAT_DBL  = 0;

  // Pin direction register fields
  localparam int SPMS_DIR_MOSI   = 0;
  localparam int SPMS_DIR_SCK    = 1;
  localparam int SPMS_DIR_MISO   = 2;
  localparam int SPMS_DIR_SS_OUT = 3;

  // Values after reset
  localparam logic [7:0] SPMS_CTL_RST = 8'h00;
  localparam logic [7:0] SPMS_DIR_RST = 8'h00;

  // Half periods of SCK in clock cycles for divisors 4, 16, 64, 128
  localparam logic [6:0] SPMS_HALF_DIV4   = 7'h02;
  localparam logic [6:0] SPMS_HALF_DIV16  = 7'h08;
  localparam logic [6:0] SPMS_HALF_DIV64  = 7'h20;
  localparam logic [6:0] SPMS_HALF_DIV128 = 7'h40;

  // SCK edges of one master byte, and bits of a byte
  localparam logic [4:0] SPMS_MST_EDGES = 5'h10;
  localparam logic [3:0] SPMS_BITS      = 4'h8;

  function automatic logic [6:0] spms_half(input logic [1:0] rate,
                                           input logic       dbl);
    logic [6:0] h;
    case (rate)
      2'h0:    h = SPMS_HALF_DIV4;
      2'h1:    h = SPMS_HALF_DIV16;
      2'h2:    h = SPMS_HALF_DIV64;
      default: h = SPMS_HALF_DIV128;
    endcase
    return dbl ? (h >> 1) : h;
  endfunction

endpackage

// *** verilog/spms_port.sv ***
// Byte-wide serial master/slave port with Avalon-MM register access.
// Assumes pins are resolved outside from out/oe; all pin inputs are async.
//
// Design decisions made here: the address map and the Avalon-MM register port.
module spms_port (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Avalon-MM register slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Serial clock pin
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  // Master out, slave in
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  // Master in, slave out
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  // Slave select, input only
  input  wire logic        ss_n_in,
  // Transfer interrupt, also the wake request
  output logic             irq
);

  typedef struct packed {
    logic [7:0]  ctl;
    logic [7:0]  dir;
    logic        dbl;
    logic        flag;
    logic        write_collision_flag;
    logic        arm_flag;
    logic        arm_write_collision_flag;
    logic [7:0]  shreg;
    logic [7:0]  rxbuf;
    logic [3:0]  bitcnt;
    logic [4:0]  edges;
    logic        busy;
    logic [6:0]  divcnt;
    logic [1:0]  sck_sy;
    logic [1:0]  mosi_sy;
    logic [1:0]  miso_sy;
    logic [1:0]  ss_sy;
    logic        sck_prev;
    logic        ss_prev;
    logic        waitreq;
    logic [31:0] rdata;
    logic        irq;
    logic        sck_o;
    logic        sck_e;
    logic        dout;
    logic        mosi_e;
    logic        miso_e;
  } spms_state_t;

  spms_state_t state_reg;
  spms_state_t state_next;

  function automatic logic out_bit(input logic [7:0] sr, input logic lsb);
    return lsb ? sr[0] : sr[7];
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] sr,
                                          input logic       b,
                                          input logic       lsb);
    return lsb ? {b, sr[7:1]} : {sr[6:0], b};
  endfunction

  always_comb begin
    spms_state_t s;
    logic        en;
    logic        mst;
    logic        cpol;
    logic        cpha;
    logic        lsb;
    logic        acc;
    logic        wr_acc;
    logic        rd_acc;
    logic        data_acc;
    logic        xfer;
    logic        edge_now;
    logic        lead;
    logic        din;
    logic [7:0]  sr_new;
    logic [31:0] rmux;
    s        = state_reg;
    en       = s.ctl[spms_pkg::SPMS_CTL_EN];
    mst      = s.ctl[spms_pkg::SPMS_CTL_MST];
    cpol     = s.ctl[spms_pkg::SPMS_CTL_CPOL];
    cpha     = s.ctl[spms_pkg::SPMS_CTL_CPHA];
    lsb      = s.ctl[spms_pkg::SPMS_CTL_ORD];
    edge_now = 1'b0;
    lead     = 1'b0;
    rmux     = 32'h00000000;
    din      = 1'b0;
    xfer     = 1'b0;
    acc      = 1'b0;
    wr_acc   = 1'b0;
    rd_acc   = 1'b0;
    data_acc = 1'b0;
    sr_new   = s.shreg;
    state_next = s;

    // Two-flop synchronisers; only stage 2, index [1], is read below
    state_next.sck_sy  = {s.sck_sy[0], sck_in};
    state_next.mosi_sy = {s.mosi_sy[0], mosi_in};
    state_next.miso_sy = {s.miso_sy[0], miso_in};
    state_next.ss_sy   = {s.ss_sy[0], ss_n_in};
    state_next.sck_prev = s.sck_sy[1];
    state_next.ss_prev  = s.ss_sy[1];
    din = mst ? s.miso_sy[1] : s.mosi_sy[1];

    // Bus slave: one wait cycle, then the accept edge
    acc    = (avs_read | avs_write) & ~s.waitreq;
    wr_acc = avs_write & acc & avs_byteenable[0];
    rd_acc = avs_read & acc;
    data_acc = (wr_acc | rd_acc) & (avs_address == spms_pkg::SPMS_DATA_OFS);
    state_next.waitreq = ~((avs_read | avs_write) & s.waitreq);
    case (avs_address)
      spms_pkg::SPMS_CTRL_OFS: rmux = {24'h000000, s.ctl};
      spms_pkg::SPMS_STAT_OFS: rmux = {24'h000000, s.flag, s.write_collision_flag,
                                       5'h00, s.dbl};
      spms_pkg::SPMS_DATA_OFS: rmux = {24'h000000, s.rxbuf};
      spms_pkg::SPMS_DIR_OFS:  rmux = {24'h000000, s.dir};
      default:                 rmux = 32'h00000000;
    endcase
    if (avs_read & s.waitreq) begin
      state_next.rdata = rmux;
    end

    // Clears come first so that any set below wins
    if (data_acc) begin
      if (s.arm_flag) state_next.flag = 1'b0;
      if (s.arm_write_collision_flag) state_next.write_collision_flag = 1'b0;
      state_next.arm_flag = 1'b0;
      state_next.arm_write_collision_flag = 1'b0;
    end
    if (rd_acc && avs_address == spms_pkg::SPMS_STAT_OFS) begin
      state_next.arm_flag = s.flag;
      state_next.arm_write_collision_flag = s.write_collision_flag;
    end
    if (wr_acc) begin
      case (avs_address)
        spms_pkg::SPMS_CTRL_OFS: state_next.ctl = avs_writedata[7:0];
        spms_pkg::SPMS_STAT_OFS:
          state_next.dbl = avs_writedata[spms_pkg::SPMS_STAT_DBL];
        spms_pkg::SPMS_DIR_OFS:  state_next.dir = avs_writedata[7:0];
        default: ;
      endcase
    end

    // Data writes: refused while a byte is moving
    xfer = s.busy | (s.bitcnt != 4'h0);
    if (wr_acc && avs_address == spms_pkg::SPMS_DATA_OFS) begin
      if (xfer) begin
        state_next.write_collision_flag = 1'b1;
      end else begin
        state_next.shreg = avs_writedata[7:0];
        sr_new = avs_writedata[7:0];
        if (en && mst) begin
          state_next.busy   = 1'b1;
          state_next.edges  = 5'h00;
          state_next.divcnt = 7'h00;
        end
      end
    end

    // Master clock generator; no edge before the write that starts it
    if (en && mst && s.busy) begin
      if (s.divcnt == spms_pkg::spms_half(s.ctl[1:0], s.dbl) - 7'h01) begin
        state_next.divcnt = 7'h00;
        state_next.sck_o  = ~s.sck_o;
        state_next.edges  = s.edges + 5'h01;
        edge_now = 1'b1;
        lead = (s.sck_o == cpol);
      end else begin
        state_next.divcnt = s.divcnt + 7'h01;
      end
    end
    // Slave follows the synchronised SCK only while selected
    if (en && !mst && !s.ss_sy[1] && (s.sck_sy[1] != s.sck_prev)) begin
      edge_now = 1'b1;
      lead = (s.sck_prev == cpol);
    end

    // Sample on one edge, present on the other
    if (edge_now) begin
      if (lead ^ cpha) begin
        sr_new = shift_in(s.shreg, din, lsb);
        state_next.shreg  = sr_new;
        state_next.bitcnt = s.bitcnt + 4'h1;
        if (!mst && s.bitcnt + 4'h1 == spms_pkg::SPMS_BITS) begin
          state_next.flag   = 1'b1;
          state_next.rxbuf  = sr_new;
          state_next.bitcnt = 4'h0;
        end
      end else begin
        state_next.dout = out_bit(s.shreg, lsb);
      end
      if (mst && s.edges + 5'h01 == spms_pkg::SPMS_MST_EDGES) begin
        state_next.busy   = 1'b0;
        state_next.flag   = 1'b1;
        state_next.rxbuf  = sr_new;
        state_next.bitcnt = 4'h0;
      end
    end else if (s.bitcnt == 4'h0 && !(s.busy && s.edges != 5'h00)) begin
      state_next.dout = out_bit(sr_new, lsb);
    end

    if (!s.busy) begin
      state_next.sck_o = cpol;
    end

    // Deselect resets the slave mid-byte
    if (en && !mst && s.ss_sy[1] && !s.ss_prev) begin
      state_next.bitcnt = 4'h0;
      if (s.bitcnt != 4'h0) state_next.shreg = 8'h00;
    end
    // Another master pulls select low
    if (en && mst && !s.dir[spms_pkg::SPMS_DIR_SS_OUT] && !s.ss_sy[1]) begin
      state_next.ctl[spms_pkg::SPMS_CTL_MST] = 1'b0;
      state_next.flag   = 1'b1;
      state_next.busy   = 1'b0;
      state_next.bitcnt = 4'h0;
      state_next.sck_o  = cpol;
    end
    if (!en) begin
      state_next.busy   = 1'b0;
      state_next.bitcnt = 4'h0;
    end

    // Pin overrides; the select pin is never driven here
    state_next.mosi_e = en & mst & s.dir[spms_pkg::SPMS_DIR_MOSI];
    state_next.sck_e  = en & mst & s.dir[spms_pkg::SPMS_DIR_SCK];
    state_next.miso_e = en & ~mst & s.dir[spms_pkg::SPMS_DIR_MISO]
                        & ~s.ss_sy[1];
    state_next.irq = state_next.flag
                     & state_next.ctl[spms_pkg::SPMS_CTL_IE];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg          <= '0;
      state_reg.ctl      <= spms_pkg::SPMS_CTL_RST;
      state_reg.dir      <= spms_pkg::SPMS_DIR_RST;
      state_reg.sck_sy   <= 2'h3;
      state_reg.ss_sy    <= 2'h3;
      state_reg.sck_prev <= 1'b1;
      state_reg.ss_prev  <= 1'b1;
      state_reg.waitreq  <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign avs_readdata    = state_reg.rdata;
  assign avs_waitrequest = state_reg.waitreq;
  assign sck_out         = state_reg.sck_o;
  assign sck_oe          = state_reg.sck_e;
  assign mosi_out        = state_reg.dout;
  assign mosi_oe         = state_reg.mosi_e;
  assign miso_out        = state_reg.dout;
  assign miso_oe         = state_reg.miso_e;
  assign irq             = state_reg.irq;

  // Checks
  logic [7:0] tog_cnt;
  logic       data_wr_acc;
  always_ff @(posedge mclk) begin
    if (rst || !state_reg.busy || state_reg.sck_o != state_next.sck_o) begin
      tog_cnt <= 8'h00;
    end else begin
      tog_cnt <= tog_cnt + 8'h01;
    end
  end
  assign data_wr_acc = avs_write & ~state_reg.waitreq & avs_byteenable[0]
                       & (avs_address == spms_pkg::SPMS_DATA_OFS);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_start;
    data_wr_acc && !state_reg.busy && state_reg.bitcnt == 4'h0
    && state_reg.ctl[spms_pkg::SPMS_CTL_EN]
    && state_reg.ctl[spms_pkg::SPMS_CTL_MST];
  endsequence
  sequence s_idle_ok;
    state_reg.ss_sy[1] && state_reg.ctl[spms_pkg::SPMS_CTL_MST]
    && state_reg.ctl[spms_pkg::SPMS_CTL_EN];
  endsequence

  a_master_start: assert property (
    s_start ##1 state_reg.ss_sy[1] |-> state_reg.busy)
    else $error("master write did not start a transfer");
  a_done_flag: assert property (
    $fell(state_reg.busy) and s_idle_ok |-> state_reg.flag)
    else $error("end of master byte without done flag");
  a_miso_release: assert property (
    state_reg.ss_sy[1] |=> !miso_oe)
    else $error("MISO driven while deselected");
  a_ss_reset: assert property (
    state_reg.ss_sy[1] && !state_reg.ss_prev
    && !state_reg.ctl[spms_pkg::SPMS_CTL_MST]
    |=> state_reg.bitcnt == 4'h0)
    else $error("slave counter not reset on deselect");
  a_mode_fault: assert property (
    state_reg.ctl[spms_pkg::SPMS_CTL_EN]
    && state_reg.ctl[spms_pkg::SPMS_CTL_MST]
    && !state_reg.dir[spms_pkg::SPMS_DIR_SS_OUT] && !state_reg.ss_sy[1]
    |=> !state_reg.ctl[spms_pkg::SPMS_CTL_MST] && state_reg.flag)
    else $error("select low did not force slave mode");
  a_write_collision_flag_set: assert property (
    data_wr_acc && state_reg.busy |=> state_reg.write_collision_flag
    && $stable(state_reg.rxbuf))
    else $error("collision flag not set on busy write");
  a_half_period: assert property (
    state_reg.busy && $changed(state_reg.sck_o) && $past(state_reg.busy)
    |-> $past(tog_cnt) + 8'h01
        == {1'b0, spms_pkg::spms_half(state_reg.ctl[1:0], state_reg.dbl)})
    else $error("SCK half period wrong");
  a_disable_oe: assert property (
    !state_reg.ctl[spms_pkg::SPMS_CTL_EN] |=> !sck_oe && !mosi_oe
    && !miso_oe && !state_reg.busy)
    else $error("pin override kept while disabled");
  a_irq_follow: assert property (
    state_reg.flag && state_reg.ctl[spms_pkg::SPMS_CTL_IE] |-> irq)
    else $error("interrupt missing with flag and enable");

endmodule // spms_port

// *** bench/spms_slave_model.sv ***
// Behavioural serial slave that faces the port while it runs as master.
// Assumes the bench gives select, mode, bit order and the byte to return.
module spms_slave_model #(
  parameter int DLY = 0
) (
  // Serial pins
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  output logic            miso,
  // Mode and data
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb,
  input  wire logic [7:0] tx,
  output logic      [7:0] rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sr;
  logic       first;
  logic       bit_out;

  initial begin
    sr = 8'h00;
    rx = 8'h00;
    first = 1'b0;
    miso = 1'b0;
  end

  always @(negedge ss_n) begin
    sr = tx;
    first = 1'b1;
  end

  // Sample on one edge, shift on the other
  always @(sck) begin
    if (!ss_n && ((sck != cpol) ^ cpha))
      rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
    else if (!ss_n && first && cpha)
      first = 1'b0;
    else if (!ss_n)
      sr = lsb ? (sr >> 1) : (sr << 1);
  end

  assign bit_out = lsb ? sr[0] : sr[7];

  // Released line: no pull, so show the inverse rather than a held value
  always @(ss_n or bit_out) begin
    if (!ss_n)
      miso <= #DLY bit_out;
    else
      miso <= #DLY ~miso;
  end
endmodule  // spms_slave_model

// *** bench/test_spms_port.sv ***
// Self-checking bench for the serial master/slave port.
// Assumes Avalon answers by waitrequest; bench plays external master.
module test_spms_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic        sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic        irq, tb_sck, tb_mosi, ss_n_in, slv_ss_n, m_miso;
  logic        cpol, cpha, lsb;
  logic [7:0]  s_tx, s_rx;
  int          err_count, samples_checked;
  wire logic   sck = sck_oe ? sck_out : tb_sck;
  wire logic   mosi = mosi_oe ? mosi_out : tb_mosi;
  wire logic   miso = miso_oe ? miso_out : m_miso;

  spms_port dut_u (.mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sck_in(sck), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso),
    .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in), .irq(irq));

  spms_slave_model slave_u (.sck(sck), .mosi(mosi), .ss_n(slv_ss_n),
    .miso(m_miso), .cpol(cpol), .cpha(cpha), .lsb(lsb), .tx(s_tx),
    .rx(s_rx));

  always #5 mclk = ~mclk;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      err_count++;
      finish_test();
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do
      @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && ++n < 64);
    tmo(n, 64);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rc(input string nm, input logic [3:0] a,
                    input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, q, {24'h0, e});
  endtask

  task automatic wirq();
    int n;
    n = 0;
    while (irq !== 1'b1 && ++n < 3000)
      @(posedge mclk);
    tmo(n, 3000);
  endtask

  // Bench as external master, mode 0, MSB first, half period 8 cycles
  task automatic sx(input logic [7:0] t, input int nb,
                    output logic [7:0] m);
    for (int i = 7; i > 7 - nb; i--) begin
      tb_mosi <= t[i];
      repeat (8) @(posedge mclk);
      m[i] = miso;
      tb_sck <= 1'b1;
      repeat (8) @(posedge mclk);
      tb_sck <= 1'b0;
    end
    repeat (8) @(posedge mclk);
  endtask

  task automatic t_master(input logic [1:0] m, input logic col);
    logic [7:0] d;
    d = 8'hb4 ^ {6'h0, m};
    cpol = m[1];
    cpha = m[0];
    lsb = ^m;
    s_tx = 8'h2d + {6'h0, m};
    wr(spms_pkg::SPMS_DIR_OFS, 8'h0b);
    wr(spms_pkg::SPMS_CTRL_OFS, {2'b11, lsb, 1'b1, m, 2'h1});
    // Let SCK settle to its new idle level before selecting the slave
    repeat (2) @(posedge mclk);
    slv_ss_n <= 1'b0;
    wr(spms_pkg::SPMS_DATA_OFS, d);
    if (col)
      wr(spms_pkg::SPMS_DATA_OFS, ~d);
    chk("pin dirs", {miso_oe, mosi_oe, sck_oe}, 3'b011);
    wirq();
    chk("sck idle", sck_out, cpol);
    rc("status", spms_pkg::SPMS_STAT_OFS, {1'b1, col, 6'h0});
    rc("rx buf", spms_pkg::SPMS_DATA_OFS, s_tx);
    rc("cleared", spms_pkg::SPMS_STAT_OFS, 8'h00);
    chk("irq low", irq, 1'b0);
    chk("slave rx", s_rx, d);
    slv_ss_n <= 1'b1;
  endtask

  task automatic t_rate();
    int n;
    int dv[4] = '{4, 16, 64, 128};
    logic [31:0] q;
    for (int r = 0; r < 8; r++) begin
      wr(spms_pkg::SPMS_STAT_OFS, 8'(r / 4));
      wr(spms_pkg::SPMS_CTRL_OFS, 8'hd0 | 8'(r % 4));
      wr(spms_pkg::SPMS_DATA_OFS, 8'h00);
      n = 0;
      while (sck_out === 1'b0 && ++n < 300)
        @(posedge mclk);
      tmo(n, 300);
      n = 0;
      while (sck_out === 1'b1 && ++n < 300)
        @(posedge mclk);
      tmo(n, 300);
      chk("half period", n, dv[r % 4] / (2 << (r / 4)));
      wirq();
      bus(1'b0, spms_pkg::SPMS_STAT_OFS, 8'h00, q);
      bus(1'b0, spms_pkg::SPMS_DATA_OFS, 8'h00, q);
    end
    wr(spms_pkg::SPMS_STAT_OFS, 8'h00);
  endtask

  task automatic t_fault();
    logic [31:0] q;
    wr(spms_pkg::SPMS_DIR_OFS, 8'h03);
    wr(spms_pkg::SPMS_CTRL_OFS, 8'h50);
    ss_n_in <= 1'b0;
    repeat (4) @(posedge mclk);
    rc("mode fault", spms_pkg::SPMS_CTRL_OFS, 8'h40);
    rc("fault flag", spms_pkg::SPMS_STAT_OFS, 8'h80);
    bus(1'b0, spms_pkg::SPMS_DATA_OFS, 8'h00, q);
    ss_n_in <= 1'b1;
  endtask

  task automatic t_slave();
    logic [7:0] m;
    wr(spms_pkg::SPMS_DIR_OFS, 8'h04);
    wr(spms_pkg::SPMS_CTRL_OFS, 8'hc0);
    wr(spms_pkg::SPMS_DATA_OFS, 8'ha7);
    sx(8'hff, 8, m);
    chk("idle pins", {miso_oe, mosi_oe, sck_oe}, 3'b000);
    rc("no shift", spms_pkg::SPMS_STAT_OFS, 8'h00);
    ss_n_in <= 1'b0;
    sx(8'h3c, 8, m);
    chk("slave tx", m, 8'ha7);
    chk("miso oe", miso_oe, 1'b1);
    rc("flag", spms_pkg::SPMS_STAT_OFS, 8'h80);
    wr(spms_pkg::SPMS_DATA_OFS, 8'h81);
    sx(8'h5e, 8, m);
    chk("slave tx2", m, 8'h81);
    rc("rx kept", spms_pkg::SPMS_DATA_OFS, 8'h5e);
    sx(8'hff, 3, m);
    ss_n_in <= 1'b1;
    repeat (8) @(posedge mclk);
    ss_n_in <= 1'b0;
    sx(8'h69, 8, m);
    rc("realigned", spms_pkg::SPMS_DATA_OFS, 8'h69);
    wr(spms_pkg::SPMS_CTRL_OFS, 8'h00);
    // Overrides follow the control register one cycle later
    repeat (2) @(posedge mclk);
    chk("released", {miso_oe, mosi_oe, sck_oe}, 3'b000);
    ss_n_in <= 1'b1;
  endtask

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    tb_sck = 1'b0;
    tb_mosi = 1'b0;
    ss_n_in = 1'b1;
    slv_ss_n = 1'b1;
    {cpol, cpha, lsb} = 3'h0;
    s_tx = 8'h00;
    err_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++)
      rc("reset", (i == 4) ? 4'h2 : 4'(i * 4), 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
      t_master(2'(i), i == 3);
    $display("test master done");
    t_rate();
    $display("test rate done");
    t_fault();
    $display("test fault done");
    t_slave();
    $display("test slave done");
    finish_test();
  end
endmodule  // test_spms_port
